// ### rtl/hs_fault_pkg.sv
package hs_fault_pkg;
  localparam int CLK_PERIOD_NS = 4;
  // protection and switching times, ns
  localparam int T_DEGLITCH_NS  = 3_000;
  localparam int T_RESTART_NS   = 2_000_000;
  localparam int T_STANDBY_NS   = 17_000_000;
  localparam int T_ON_DELAY_NS  = 60_000;
  localparam int T_ON_DONE_NS   = 94_000;
  // sense settling limits, ns
  localparam int T_SNS_DIAG_NS  = 40_000;
  localparam int T_SNS_BOTH_NS  = 200_000;
  localparam int T_SNS_EN_NS    = 165_000;
  localparam int T_SNS_OFF_NS   = 20_000;
  localparam int T_SNS_STEP_NS  = 20_000;
  localparam int T_SNS_TOFF_NS  = 70_000;
  localparam int T_SNS_MUX_NS   = 60_000;
  localparam int T_SNS_FAULT_NS = 50_000;
  localparam int GLITCH_CYC = (T_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FOLDBACK_COUNT = 7;
  // pin vector positions
  localparam int PIN_EN    = 0;
  localparam int PIN_DIAG  = 1;
  localparam int PIN_SEL   = 2;
  localparam int PIN_HOLD  = 3;
  localparam int PIN_AHOT  = 4;
  localparam int PIN_ACOOL = 5;
  localparam int PIN_RHOT  = 6;
  localparam int PIN_OC    = 7;
  localparam int PIN_UVF   = 8;
  localparam int PIN_UVR   = 9;
  localparam int PIN_RBAD  = 10;
  localparam int PIN_STEP  = 11;
  localparam int NUM_PINS  = 12;
  // register map
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam int CTRL_RANGE_BIT = 0;
  localparam int CTRL_INHIB_BIT = 1;
  localparam int ST_FAULT_BIT   = 0;
  localparam int ST_ABS_BIT     = 1;
  localparam int ST_REL_BIT     = 2;
  localparam int ST_OC_BIT      = 3;
  localparam int ST_UV_BIT      = 4;
  localparam int ST_STBY_BIT    = 5;
  localparam int ST_HALF_BIT    = 6;
  localparam int ST_INTL_BIT    = 7;
  localparam int ST_GATE_BIT    = 8;
  localparam int ST_DONE_BIT    = 9;
  localparam int ST_SETL_BIT    = 10;
  localparam int ST_FCNT_LSB    = 12;
  localparam int ST_STATE_LSB   = 16;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ST_OFF      = 4'b0000,
    ST_ON_DLY   = 4'b0001,
    ST_ON_RAMP  = 4'b0010,
    ST_ON       = 4'b0011,
    ST_OFF_DLY  = 4'b0100,
    ST_OFF_RAMP = 4'b0101,
    ST_FAULT    = 4'b0110,
    ST_UVLO     = 4'b0111,
    ST_STANDBY  = 4'b1000
  } sw_state_e;

  typedef enum logic [1:0] {
    SNS_INACTIVE = 2'b00,
    SNS_CURRENT  = 2'b01,
    SNS_TEMP     = 2'b10,
    SNS_FAULT    = 2'b11
  } sense_mode_e;
endpackage

// ### rtl/high_side_fault_control.sv
`timescale 1ns/1ps
// Contract
// RULE1 - thermal or current-limit trip turns switch off, enters fault state
// RULE2 - in fault state sense output shows fault indication level
// RULE3 - leave fault only: hold low, restart wait done, faults cleared
// RULE4 - thermal fault on absolute limit or relative limit exceeded
// RULE5 - absolute fault clears by hysteresis, relative after restart wait
// RULE6 - current at limit threshold switches channel off, enters fault
// RULE7 - overcurrent must persist 3 us before counting as short
// RULE8 - high range only: seven consecutive faults halve current limit
// RULE9 - limit restored on standby or on clean on-off cycle
// RULE10 - bad limit resistor selects fixed internal limit
// RULE11 - undervoltage fall stops output stage, rise resumes
// RULE12 - host keeps enable low during slow supply ramp
// RULE13 - current sense settles in 40, 200 or 165 us by case
// RULE14 - sense goes inactive within 20 us of diag enable falling
// RULE15 - current sense settles 20 us after load step
// RULE16 - temperature sense settles 40 us switch on, 70 us off
// RULE17 - sense select change settles within 60 us
// RULE18 - output starts moving 20 to 100 us after enable edge
// RULE19 - output transition completes 39 to 235 us after edge
// RULE20 - restart wait lasts 1 to 3 ms
// RULE21 - fault level on sense within 50 us of shutdown
// RULE22 - standby 12 to 22 ms after both enables low
// RULE23 - no fault: select low reports current, high reports temperature
// RULE24 - fault counter counts shutdowns, saturates, clears on restore
// RULE25 - timers clocked internally, cleared during undervoltage
module high_side_fault_control
  import hs_fault_pkg::*;
#(
  parameter int unsigned RESTART_CYC = T_RESTART_NS / CLK_PERIOD_NS,
  parameter int unsigned STBY_CYC    = T_STANDBY_NS / CLK_PERIOD_NS,
  parameter int unsigned ON_DLY_CYC  = T_ON_DELAY_NS / CLK_PERIOD_NS,
  parameter int unsigned ON_DONE_CYC = T_ON_DONE_NS / CLK_PERIOD_NS,
  parameter int unsigned SNS_DIAG_CYC  = T_SNS_DIAG_NS / CLK_PERIOD_NS,
  parameter int unsigned SNS_BOTH_CYC  = T_SNS_BOTH_NS / CLK_PERIOD_NS,
  parameter int unsigned SNS_EN_CYC    = T_SNS_EN_NS / CLK_PERIOD_NS,
  parameter int unsigned SNS_OFF_CYC   = T_SNS_OFF_NS / CLK_PERIOD_NS,
  parameter int unsigned SNS_STEP_CYC  = T_SNS_STEP_NS / CLK_PERIOD_NS,
  parameter int unsigned SNS_TOFF_CYC  = T_SNS_TOFF_NS / CLK_PERIOD_NS,
  parameter int unsigned SNS_MUX_CYC   = T_SNS_MUX_NS / CLK_PERIOD_NS,
  parameter int unsigned SNS_FAULT_CYC = T_SNS_FAULT_NS / CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // host control pins
  input  wire logic        enable,
  input  wire logic        diag_enable,
  input  wire logic        sense_select,
  input  wire logic        fault_hold,
  // analog comparators
  input  wire logic        abs_over_temp,
  input  wire logic        abs_cooled,
  input  wire logic        rel_over_temp,
  input  wire logic        over_current,
  input  wire logic        uv_fall,
  input  wire logic        uv_rise,
  input  wire logic        limit_set_bad,
  input  wire logic        load_step,
  // output stage
  output logic             gate_on,
  output logic             out_complete,
  output logic             fault_state,
  output logic             standby,
  output logic             current_limit_half,
  output logic             limit_internal,
  // sense multiplexer
  output logic [1:0]       sense_mode,
  output logic             sense_settled,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int SEQ_W  = $clog2(ON_DONE_CYC + 1);
  localparam int STBY_W = $clog2(STBY_CYC + 1);
  localparam int RTY_W  = $clog2(RESTART_CYC + 1);
  localparam int GL_W   = $clog2(GLITCH_CYC + 1);
  // longest case: both enables together
  localparam int SNS_W  = $clog2(SNS_BOTH_CYC + 1);

  typedef struct packed {
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] sync3;
    logic [NUM_PINS-1:0] pin;
    logic [NUM_PINS-1:0] prev;
    sw_state_e           state;
    logic [SEQ_W-1:0]    seq_cnt;
    logic [STBY_W-1:0]   stby_cnt;
    logic [RTY_W-1:0]    rty_cnt;
    logic                rty_done;
    logic [GL_W-1:0]     gl_cnt;
    logic                abs_flt;
    logic                rel_flt;
    logic                oc_flt;
    logic                uv;
    logic [2:0]          fcnt;
    logic                cyc_fault;
    logic                gate;
    logic                done;
    logic                half;
    logic                intl;
    sense_mode_e         mode;
    logic [SNS_W-1:0]    settle_cnt;
    logic                settled;
    logic                high_range;
    logic                inhibit;
    logic [15:0]         shutdowns;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
  } state_s;

  state_s q, d;
  logic [NUM_PINS-1:0] pins_in;
  logic [NUM_PINS-1:0] agree;
  logic en_rise, diag_rise, diag_fall, sel_chg, step_rise;
  logic trip, oc_trip, fault_entry, aw_go, ar_go;
  logic [31:0] status;
  logic [SNS_W-1:0] sns_load;
  logic sns_ld;

  assign pins_in = {load_step, limit_set_bad, uv_rise, uv_fall, over_current,
                    rel_over_temp, abs_cooled, abs_over_temp, fault_hold,
                    sense_select, diag_enable, enable};
  assign agree = ~(q.sync2 ^ q.sync3);

  assign en_rise   = q.pin[PIN_EN] & ~q.prev[PIN_EN];
  assign diag_rise = q.pin[PIN_DIAG] & ~q.prev[PIN_DIAG];
  assign diag_fall = ~q.pin[PIN_DIAG] & q.prev[PIN_DIAG];
  assign sel_chg   = q.pin[PIN_SEL] ^ q.prev[PIN_SEL];
  assign step_rise = q.pin[PIN_STEP] & ~q.prev[PIN_STEP];

  assign aw_go = s_axi_awvalid & s_axi_wvalid & ~q.bvalid;
  assign ar_go = s_axi_arvalid & ~q.rvalid;

  always_comb begin
    status = '0;
    status[ST_FAULT_BIT] = (q.state == ST_FAULT);
    status[ST_ABS_BIT]   = q.abs_flt;
    status[ST_REL_BIT]   = q.rel_flt;
    status[ST_OC_BIT]    = q.oc_flt;
    status[ST_UV_BIT]    = q.uv;
    status[ST_STBY_BIT]  = (q.state == ST_STANDBY);
    status[ST_HALF_BIT]  = q.half;
    status[ST_INTL_BIT]  = q.intl;
    status[ST_GATE_BIT]  = q.gate;
    status[ST_DONE_BIT]  = q.done;
    status[ST_SETL_BIT]  = q.settled;
    status[ST_FCNT_LSB +: 3]  = q.fcnt;
    status[ST_STATE_LSB +: 4] = q.state;
  end

  always_comb begin
    d = q;
    fault_entry = 1'b0;
    sns_ld = 1'b0;
    sns_load = '0;
    // 3-stage sync; change taken when stages 2 and 3 agree
    d.sync1 = pins_in;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    d.pin   = (q.pin & ~agree) | (q.sync3 & agree);
    d.prev  = q.pin;

    // supply monitor, fall wins when both seen
    if (q.pin[PIN_UVR]) d.uv = 1'b0; // RULE11
    if (q.pin[PIN_UVF]) d.uv = 1'b1; // RULE11

    // thermal flags; a new trip wins over a same-cycle clear
    if (q.pin[PIN_ACOOL]) d.abs_flt = 1'b0; // RULE5
    if (q.state == ST_FAULT && q.rty_done) d.rel_flt = 1'b0; // RULE5
    if (q.pin[PIN_AHOT]) d.abs_flt = 1'b1; // RULE4
    if (q.pin[PIN_RHOT]) d.rel_flt = 1'b1; // RULE4

    // overcurrent deglitch, only while the stage drives
    if (q.gate && q.pin[PIN_OC]) begin
      if (q.gl_cnt != GL_W'(GLITCH_CYC)) d.gl_cnt = q.gl_cnt + 1'b1; // RULE7
    end else begin
      d.gl_cnt = '0;
    end
    oc_trip = q.gate && q.pin[PIN_OC] && (q.gl_cnt == GL_W'(GLITCH_CYC - 1)); // RULE7
    if (q.state == ST_FAULT && !q.pin[PIN_OC]) d.oc_flt = 1'b0;
    if (oc_trip) d.oc_flt = 1'b1; // RULE6
    trip = q.pin[PIN_AHOT] | q.pin[PIN_RHOT] | oc_trip; // RULE1

    if (q.seq_cnt != SEQ_W'(ON_DONE_CYC)) d.seq_cnt = q.seq_cnt + 1'b1;

    unique case (q.state)
      ST_UVLO: begin
        d.gate = 1'b0;
        d.done = 1'b0;
        if (!q.uv) d.state = ST_OFF; // RULE11
      end
      ST_STANDBY: begin
        if (q.pin[PIN_EN] || q.pin[PIN_DIAG]) d.state = ST_OFF;
      end
      ST_OFF: begin
        d.gate = 1'b0;
        d.done = 1'b0;
        if (q.pin[PIN_EN] && !q.inhibit) begin
          d.state = ST_ON_DLY;
          d.seq_cnt = '0;
          d.cyc_fault = 1'b0;
          d.stby_cnt = '0;
        end else if (!q.pin[PIN_EN] && !q.pin[PIN_DIAG]) begin
          d.stby_cnt = q.stby_cnt + 1'b1;
          if (q.stby_cnt == STBY_W'(STBY_CYC - 1)) begin // RULE22
            d.state = ST_STANDBY;
            d.stby_cnt = '0;
            d.fcnt = '0; // RULE9
          end
        end else begin
          d.stby_cnt = '0;
        end
      end
      ST_ON_DLY: begin
        if (!q.pin[PIN_EN] || q.inhibit) begin
          d.state = ST_OFF;
        end else if (q.seq_cnt == SEQ_W'(ON_DLY_CYC - 1)) begin
          d.gate = 1'b1; // RULE18
          d.state = ST_ON_RAMP;
        end
      end
      ST_ON_RAMP: begin
        if (!q.pin[PIN_EN] || q.inhibit) begin
          d.state = ST_OFF_DLY;
          d.seq_cnt = '0;
        end else if (q.seq_cnt == SEQ_W'(ON_DONE_CYC - 1)) begin
          d.done = 1'b1; // RULE19
          d.state = ST_ON;
        end
      end
      ST_ON: begin
        if (!q.pin[PIN_EN] || q.inhibit) begin
          d.state = ST_OFF_DLY;
          d.seq_cnt = '0;
        end
      end
      ST_OFF_DLY: begin
        if (q.seq_cnt == SEQ_W'(ON_DLY_CYC - 1)) begin
          d.gate = 1'b0; // RULE18
          d.state = ST_OFF_RAMP;
        end
      end
      ST_OFF_RAMP: begin
        if (q.seq_cnt == SEQ_W'(ON_DONE_CYC - 1)) begin
          d.done = 1'b0; // RULE19
          d.state = ST_OFF;
          if (!q.cyc_fault) d.fcnt = '0; // RULE9 RULE24
        end
      end
      ST_FAULT: begin
        d.gate = 1'b0;
        d.done = 1'b0;
        if (!q.rty_done) begin
          d.rty_cnt = q.rty_cnt + 1'b1;
          if (q.rty_cnt == RTY_W'(RESTART_CYC - 1)) d.rty_done = 1'b1; // RULE20
        end
        // release once nothing holds it
        if (!q.pin[PIN_HOLD] && q.rty_done && !q.abs_flt && !q.rel_flt
            && !q.oc_flt) begin // RULE3
          d.seq_cnt = '0;
          d.state = (q.pin[PIN_EN] && !q.inhibit) ? ST_ON_DLY : ST_OFF;
        end
      end
      default: begin
        d.state = ST_OFF;
        d.gate = 1'b0;
        d.done = 1'b0;
      end
    endcase

    if (trip && q.state != ST_FAULT && q.state != ST_UVLO) begin
      fault_entry = 1'b1;
      d.state = ST_FAULT; // RULE1 RULE6
      d.gate = 1'b0;
      d.done = 1'b0;
      d.rty_cnt = '0;
      d.rty_done = 1'b0;
      d.cyc_fault = 1'b1;
      d.shutdowns = q.shutdowns + 1'b1;
      if (q.fcnt != 3'(FOLDBACK_COUNT)) d.fcnt = q.fcnt + 1'b1; // RULE24
    end

    // undervoltage wins and clears the timers
    if (q.uv) begin
      d.state = ST_UVLO; // RULE11
      d.gate = 1'b0;
      d.done = 1'b0;
      d.seq_cnt = '0; // RULE25
      d.stby_cnt = '0; // RULE25
      d.rty_cnt = '0; // RULE25
      d.rty_done = 1'b0;
      d.gl_cnt = '0; // RULE25
      fault_entry = 1'b0;
    end

    d.half = q.high_range && (d.fcnt == 3'(FOLDBACK_COUNT)); // RULE8
    d.intl = q.pin[PIN_RBAD]; // RULE10

    // sense multiplexer
    if (!q.pin[PIN_DIAG]) d.mode = SNS_INACTIVE; // RULE14
    else if (d.state == ST_FAULT) d.mode = SNS_FAULT; // RULE2
    else if (q.pin[PIN_SEL]) d.mode = SNS_TEMP; // RULE23
    else d.mode = SNS_CURRENT; // RULE23

    if (diag_fall) begin
      sns_ld = 1'b1;
      sns_load = SNS_W'(SNS_OFF_CYC); // RULE14
    end else if (fault_entry && q.pin[PIN_DIAG]) begin
      sns_ld = 1'b1;
      sns_load = SNS_W'(SNS_FAULT_CYC); // RULE21
    end else if (sel_chg && q.pin[PIN_DIAG]) begin
      sns_ld = 1'b1;
      sns_load = SNS_W'(SNS_MUX_CYC); // RULE17
    end else if (diag_rise && q.pin[PIN_SEL]) begin
      sns_ld = 1'b1;
      sns_load = q.gate ? SNS_W'(SNS_DIAG_CYC) : SNS_W'(SNS_TOFF_CYC); // RULE16
    end else if (diag_rise) begin
      sns_ld = 1'b1;
      sns_load = en_rise ? SNS_W'(SNS_BOTH_CYC) : SNS_W'(SNS_DIAG_CYC); // RULE13
    end else if (en_rise && q.pin[PIN_DIAG] && !q.pin[PIN_SEL]) begin
      sns_ld = 1'b1;
      sns_load = SNS_W'(SNS_EN_CYC); // RULE13
    end else if (step_rise && q.pin[PIN_DIAG] && !q.pin[PIN_SEL] && q.done) begin
      sns_ld = 1'b1;
      sns_load = SNS_W'(SNS_STEP_CYC); // RULE15
    end
    // settled only at the guaranteed limit
    if (sns_ld) d.settle_cnt = sns_load;
    else if (q.settle_cnt != '0) d.settle_cnt = q.settle_cnt - 1'b1;
    d.settled = (d.settle_cnt == '0);

    // register write
    if (aw_go) begin
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (s_axi_awaddr == ADDR_CTRL) begin
        if (s_axi_wstrb[0]) begin
          d.high_range = s_axi_wdata[CTRL_RANGE_BIT];
          d.inhibit = s_axi_wdata[CTRL_INHIB_BIT];
        end
      end else if (s_axi_awaddr != ADDR_STAT && s_axi_awaddr != ADDR_COUNT) begin
        d.bresp = RESP_SLVERR;
      end
    end else if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // register read
    if (ar_go) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = '0;
      if (s_axi_araddr == ADDR_CTRL) begin
        d.rdata[CTRL_RANGE_BIT] = q.high_range;
        d.rdata[CTRL_INHIB_BIT] = q.inhibit;
      end else if (s_axi_araddr == ADDR_STAT) begin
        d.rdata = status;
      end else if (s_axi_araddr == ADDR_COUNT) begin
        d.rdata[15:0] = q.shutdowns;
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  // one register for all state; ce low freezes the lot
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign gate_on            = q.gate;
  assign out_complete       = q.done;
  assign fault_state        = (q.state == ST_FAULT);
  assign standby            = (q.state == ST_STANDBY);
  assign current_limit_half = q.half;
  assign limit_internal     = q.intl;
  assign sense_mode         = q.mode;
  assign sense_settled      = q.settled;
  assign s_axi_awready      = aw_go;
  assign s_axi_wready       = aw_go;
  assign s_axi_bvalid       = q.bvalid;
  assign s_axi_bresp        = q.bresp;
  assign s_axi_arready      = ar_go;
  assign s_axi_rvalid       = q.rvalid;
  assign s_axi_rresp        = q.rresp;
  assign s_axi_rdata        = q.rdata;
endmodule

// ### test/hs_host_model.sv
`timescale 1ns/1ps
module hs_host_model (
  // bench side
  input  wire logic       clk,
  input  wire logic [3:0] want,
  input  wire logic       supply_low,
  // control pins
  output logic            enable,
  output logic            diag_enable,
  output logic            sense_select,
  output logic            fault_hold
);
  initial {fault_hold, sense_select, diag_enable, enable} = 4'h0;
  // pins change just after an edge
  always @(posedge clk) begin
    enable       <= want[0] & ~supply_low;
    diag_enable  <= want[1];
    sense_select <= want[2];
    fault_hold   <= want[3];
  end
endmodule

// ### test/high_side_fault_control_chk.sv
`timescale 1ns/1ps
module hs_fault_chk
  import hs_fault_pkg::*;
#(
  parameter int unsigned RESTART_CYC = 50,
  parameter int unsigned ON_DLY_CYC  = 20
) (
  // clock and pins
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       enable,
  input wire logic       diag_enable,
  input wire logic       sense_select,
  input wire logic       fault_hold,
  input wire logic       uv_fall,
  // outputs
  input wire logic       gate_on,
  input wire logic       out_complete,
  input wire logic       fault_state,
  input wire logic       standby,
  input wire logic       current_limit_half,
  input wire logic [1:0] sense_mode
);
  logic [19:0] flt_q;
  logic [19:0] en_q;
  // wide enough for the restart and on-delay counts; wraps if held past 2^20 cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flt_q <= 20'h0_0000;
      en_q  <= 20'h0_0000;
    end else begin
      flt_q <= fault_state ? flt_q + 20'h0_0001 : 20'h0_0000;
      en_q  <= enable ? en_q + 20'h0_0001 : 20'h0_0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_fault_gate_off: assert property (fault_state [*2] |-> !gate_on)
    else $error("gate on in fault");
  chk_fault_sense: assert property ($rose(fault_state) && diag_enable |->
    ##[0:20] (sense_mode == SNS_FAULT || !fault_state))
    else $error("no fault level");
  chk_restart_min: assert property ($fell(fault_state) && !uv_fall |-> flt_q >= RESTART_CYC)
    else $error("fault left early");
  chk_hold_keeps: assert property (fault_hold [*8] ##0 fault_state |=> fault_state)
    else $error("fault left under hold");
  chk_on_delay: assert property ($rose(gate_on) |-> en_q >= ON_DLY_CYC)
    else $error("gate too early");
  chk_on_done: assert property ($rose(gate_on) |-> ##[18:22] (out_complete || !gate_on))
    else $error("no completion");
  chk_uv_off: assert property (uv_fall [*8] |-> !gate_on)
    else $error("gate on in undervoltage");
  chk_half_fault: assert property ($rose(current_limit_half) |-> fault_state)
    else $error("half without fault");
  chk_stby_full: assert property (standby [*2] |-> !current_limit_half && !gate_on)
    else $error("standby kept half");
  chk_temp_sel: assert property ((diag_enable && sense_select && !fault_state && !uv_fall) [*8]
    |-> sense_mode == SNS_TEMP)
    else $error("temp not shown");
  chk_diag_off: assert property ($fell(diag_enable) |->
    ##[1:20] (sense_mode == SNS_INACTIVE || diag_enable || fault_state))
    else $error("sense stays active");
  cov_fault: cover property ($rose(fault_state));
  cov_half: cover property ($rose(current_limit_half));
  cov_stby: cover property ($rose(standby));
endmodule
bind high_side_fault_control hs_fault_chk #(
  .RESTART_CYC(RESTART_CYC),
  .ON_DLY_CYC (ON_DLY_CYC)
) u_chk (
  .clk, .rst, .enable, .diag_enable, .sense_select, .fault_hold, .uv_fall, .gate_on,
  .out_complete, .fault_state, .standby, .current_limit_half, .sense_mode
);

// ### test/high_side_fault_control_bench.sv
`timescale 1ns/1ps
module automatic high_side_fault_control_bench import hs_fault_pkg::*;;
  localparam int RC = 50, DC = 20, OC = 40, SB = 30, SM = 9, SS = 8;
  logic        clk, rst, ce, aot, acool, rot, oc, uvf, uvr, lbad, lstep;
  logic [3:0]  want;
  logic        enable, diag_enable, sense_select, fault_hold;
  logic        gate_on, out_complete, fault_state, standby, current_limit_half;
  logic        limit_internal, sense_settled;
  logic [1:0]  sense_mode, s_axi_bresp, s_axi_rresp;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [6:0]  mon;
  int          n_errors = 0;
  int          comparisons = 0;
  assign mon = {sense_settled, limit_internal, current_limit_half, standby, fault_state,
                out_complete, gate_on};
  always #2 clk = ~clk;
  hs_host_model host (.clk, .want, .supply_low(uvf), .enable, .diag_enable, .sense_select,
                      .fault_hold);
  high_side_fault_control #(.RESTART_CYC(RC), .STBY_CYC(100), .ON_DLY_CYC(DC),
    .ON_DONE_CYC(OC), .SNS_DIAG_CYC(10), .SNS_BOTH_CYC(SB), .SNS_EN_CYC(25),
    .SNS_OFF_CYC(SS), .SNS_STEP_CYC(SS), .SNS_TOFF_CYC(12), .SNS_MUX_CYC(SM),
    .SNS_FAULT_CYC(SS)) uut (
    .abs_over_temp(aot), .abs_cooled(acool), .rel_over_temp(rot), .over_current(oc),
    .uv_fall(uvf), .uv_rise(uvr), .limit_set_bad(lbad), .load_step(lstep), .*);
  task end_of_test();
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tick(inout int n);
    @(posedge clk);
    n++;
  endtask
  task lapse(input int n, input int lim);
    if (n >= lim) begin
      check("wait", 32'h0000_0000, 32'h0000_0001);
      end_of_test();
    end
  endtask
  task wt(input int i, input logic v, input int lim, output int n);
    n = 0;
    while (mon[i] !== v && n < lim) tick(n);
    lapse(n, lim);
  endtask
  function logic inr(input int n, input int lo, input int hi);
    return n >= lo && n <= hi;
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do tick(n); while (s_axi_awready !== 1'b1 && n < 50);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    do tick(n); while (s_axi_bvalid !== 1'b1 && n < 50);
    check("bresp", s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    lapse(n, 50);
    tick(n);
  endtask
  task rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n = 0;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do tick(n); while (s_axi_arready !== 1'b1 && n < 50);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    check("rresp", s_axi_rresp, er);
    s_axi_rready <= 1'b0;
    lapse(n, 50);
    tick(n);
  endtask
  task t_regs();
    logic [31:0] d;
    rd(ADDR_CTRL, RESP_OKAY, d);
    check("ctrl reset", d, 32'h0000_0000);
    wr(ADDR_COUNT, 32'h0000_1234, RESP_OKAY);
    rd(ADDR_COUNT, RESP_OKAY, d);
    check("count", d, 32'h0000_0000);
    wr(8'h0c, 32'h0000_0001, RESP_SLVERR);
    rd(8'h0c, RESP_SLVERR, d);
    check("unmapped", d, 32'h0000_0000);
    wr(ADDR_CTRL, 32'hffff_ffff, RESP_OKAY);
    rd(ADDR_CTRL, RESP_OKAY, d);
    check("ctrl", d, 32'h0000_0003);
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
  endtask
  task t_switch();
    int n;
    for (int k = 1; k >= 0; k--) begin
      want <= k[3:0];
      wt(0, k[0], 100, n);
      check("edge delay", inr(n, DC + 3, DC + 8), 1'b1);
      wt(1, k[0], 100, n);
      check("edge done", inr(n, OC - DC - 1, OC - DC + 1), 1'b1);
    end
  endtask
  task settle(output int n);
    wt(6, 1'b0, 20, n);
    wt(6, 1'b1, 100, n);
  endtask
  task t_sense();
    int n;
    want <= 4'h3;
    settle(n);
    check("both", inr(n, SB - 1, SB + 1), 1'b1);
    check("cur", sense_mode, SNS_CURRENT);
    want <= 4'h7;
    settle(n);
    check("mux", inr(n, SM - 1, SM + 1), 1'b1);
    check("temp", sense_mode, SNS_TEMP);
    want <= 4'h3;
    settle(n);
    lstep <= 1'b1;
    settle(n);
    check("step", inr(n, SS - 1, SS + 1), 1'b1);
    lstep <= 1'b0;
    want <= 4'h1;
    repeat (16) @(posedge clk);
    check("diag off", sense_mode, SNS_INACTIVE);
  endtask
  task t_deglitch();
    int n;
    want <= 4'h3;
    oc <= 1'b1;
    repeat (600) @(posedge clk);
    oc <= 1'b0;
    repeat (8) @(posedge clk);
    check("glitch", fault_state, 1'b0);
    oc <= 1'b1;
    wt(2, 1'b1, 900, n);
    check("deglitch", inr(n, GLITCH_CYC, GLITCH_CYC + 10), 1'b1);
    repeat (20) @(posedge clk);
    check("gate", gate_on, 1'b0);
    check("fault lvl", sense_mode, SNS_FAULT);
    oc <= 1'b0;
    wt(2, 1'b0, 100, n);
    check("restart", n + 20 >= RC, 1'b1);
    wt(1, 1'b1, 100, n);
    want <= 4'h0;
    wt(1, 1'b0, 100, n);
  endtask
  task rel(input int k);
    int n;
    repeat (k) begin
      rot <= 1'b1;
      wt(2, 1'b1, 20, n);
      rot <= 1'b0;
      wt(2, 1'b0, 100, n);
    end
  endtask
  task t_foldback();
    int n;
    logic [31:0] d;
    // standby first: the retry cycle before left one fault counted
    wt(3, 1'b1, 200, n);
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    rel(6);
    check("early half", current_limit_half, 1'b0);
    rel(1);
    check("half", current_limit_half, 1'b1);
    rd(ADDR_STAT, RESP_OKAY, d);
    check("fcount", d[ST_FCNT_LSB +: 3], 3'h7);
    wt(3, 1'b1, 200, n);
    check("restore", current_limit_half, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    want <= 4'h2;
    wt(3, 1'b0, 20, n);
    rel(7);
    check("low range", current_limit_half, 1'b0);
  endtask
  task t_hold();
    int n;
    want <= 4'ha;
    rel(0);
    rot <= 1'b1;
    wt(2, 1'b1, 20, n);
    rot <= 1'b0;
    repeat (RC + 20) @(posedge clk);
    check("hold", fault_state, 1'b1);
    want <= 4'h2;
    wt(2, 1'b0, 20, n);
    aot <= 1'b1;
    wt(2, 1'b1, 20, n);
    aot <= 1'b0;
    repeat (RC + 20) @(posedge clk);
    check("not cooled", fault_state, 1'b1);
    acool <= 1'b1;
    wt(2, 1'b0, 20, n);
    acool <= 1'b0;
  endtask
  task t_uv();
    int n;
    logic [31:0] d;
    want <= 4'h3;
    wt(1, 1'b1, 100, n);
    uvf <= 1'b1;
    repeat (8) @(posedge clk);
    check("uv gate", gate_on, 1'b0);
    rd(ADDR_STAT, RESP_OKAY, d);
    check("uv flag", d[ST_UV_BIT], 1'b1);
    {uvf, uvr} <= 2'h1;
    wt(0, 1'b1, 100, n);
    uvr <= 1'b0;
    lbad <= 1'b1;
    wt(5, 1'b1, 20, n);
    lbad <= 1'b0;
    wt(5, 1'b0, 20, n);
    want <= 4'h0;
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    want = 4'h0;
    {aot, acool, rot, oc, uvf, uvr, lbad, lstep} = 8'h00;
    {s_axi_awaddr, s_axi_araddr} = 16'h0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_switch();
    t_sense();
    t_deglitch();
    t_foldback();
    t_hold();
    t_uv();
    end_of_test();
  end
endmodule
